/* rtl/adc_control_registers.sv */
// Register-level control of a 10-bit converter, reached over APB
`timescale 1ns/1ps
module adc_control_registers (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog core: sample result from its own domain, passes a synchroniser
    input wire logic [9:0] analog_sample,
    output logic [2:0] input_channel_select,
    output logic converter_power_on,
    output logic sample_hold,
    output logic irq
);

    adc_ctrl_pkg::apb_req_t req;
    adc_ctrl_pkg::conv_result_t res_reg;
    adc_ctrl_pkg::conv_state_t state_reg;
    logic [7:0] csr_reg;
    logic div4_reg;
    logic done_reg;
    logic [1:0] div_cnt_reg;
    logic [3:0] phase_cnt_reg;
    logic [9:0] sample_meta_reg;
    logic [9:0] sample_sync_reg;
    logic [9:0] result_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;
    logic [31:0] prdata_next;
    logic pslverr_next;
    logic acc;
    logic wr;
    logic rd;
    logic csr_wr;
    logic upper_rd;
    logic tick;
    logic [1:0] div_top;
    logic complete;
    logic aborted;

    // Register index from byte address
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        return a[11:adc_ctrl_pkg::addr_lsb] == {2'h0, idx} && a[1:0] == 2'h0;
    endfunction

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    // Setup cycle registers the answer, access cycle completes: no wait state
    assign acc = req.psel && req.penable && pready;
    assign wr = acc && req.pwrite;
    assign rd = acc && !req.pwrite;
    assign csr_wr = wr && hit(req.paddr, adc_ctrl_pkg::idx_control_status);
    assign upper_rd = rd && hit(req.paddr, adc_ctrl_pkg::idx_result_upper);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= req.psel && !pready;
        end
    end

    // Control/status register; done flag lives in done_reg
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csr_reg <= adc_ctrl_pkg::reset_byte;
        end else if (csr_wr) begin
            // Reserved bits are masked even if software breaks the convention
            csr_reg <= req.pwdata[7:0] & adc_ctrl_pkg::csr_write_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div4_reg <= 1'b0;
        end else if (wr && hit(req.paddr, adc_ctrl_pkg::idx_result_lower)) begin
            div4_reg <= req.pwdata[adc_ctrl_pkg::div4_bit];
        end
    end

    // Converter clock as a tick every 1, 2 or 4 cpu cycles
    always_comb begin
        if (div4_reg) begin
            div_top = adc_ctrl_pkg::div_by_four_top;
        end else if (csr_reg[adc_ctrl_pkg::fast_bit]) begin
            div_top = 2'h0;
        end else begin
            div_top = adc_ctrl_pkg::div_by_two_top;
        end
    end
    assign tick = div_cnt_reg >= div_top;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 2'h0;
        end else if (tick || csr_wr || state_reg == adc_ctrl_pkg::st_idle) begin
            div_cnt_reg <= 2'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 2'h1;
        end
    end

    assign aborted = !csr_reg[adc_ctrl_pkg::power_bit];
    assign complete = state_reg == adc_ctrl_pkg::st_convert && tick
        && phase_cnt_reg == adc_ctrl_pkg::convert_periods - 4'h1 && !csr_wr && !aborted;

    // Sequencer: any control write with the power bit set starts or restarts a conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= adc_ctrl_pkg::st_idle;
            phase_cnt_reg <= 4'h0;
        end else if (csr_wr && req.pwdata[adc_ctrl_pkg::power_bit]) begin
            state_reg <= adc_ctrl_pkg::st_load;
            phase_cnt_reg <= 4'h0;
        end else if (aborted) begin
            state_reg <= adc_ctrl_pkg::st_idle;
            phase_cnt_reg <= 4'h0;
        end else if (tick) begin
            case (state_reg)
                adc_ctrl_pkg::st_load: begin
                    if (phase_cnt_reg == adc_ctrl_pkg::load_periods - 4'h1) begin
                        state_reg <= adc_ctrl_pkg::st_convert;
                        phase_cnt_reg <= 4'h0;
                    end else begin
                        phase_cnt_reg <= phase_cnt_reg + 4'h1;
                    end
                end
                adc_ctrl_pkg::st_convert: begin
                    if (phase_cnt_reg == adc_ctrl_pkg::convert_periods - 4'h1) begin
                        // Continuous: reload the next sample at once
                        state_reg <= adc_ctrl_pkg::st_load;
                        phase_cnt_reg <= 4'h0;
                    end else begin
                        phase_cnt_reg <= phase_cnt_reg + 4'h1;
                    end
                end
                default: begin
                    state_reg <= adc_ctrl_pkg::st_idle;
                    phase_cnt_reg <= 4'h0;
                end
            endcase
        end
    end

    // Two-stage synchroniser on the analog core's result bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_meta_reg <= 10'h000;
            sample_sync_reg <= 10'h000;
        end else begin
            sample_meta_reg <= analog_sample;
            sample_sync_reg <= sample_meta_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 10'h000;
        end else if (complete) begin
            result_reg <= sample_sync_reg;
        end
    end
    assign res_reg = '{data: result_reg, valid: done_reg};

    // Done flag: completion wins over the clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_reg <= 1'b0;
        end else if (complete) begin
            done_reg <= 1'b1;
        end else if (upper_rd || (csr_wr && req.pwdata[adc_ctrl_pkg::power_bit])) begin
            done_reg <= 1'b0;
        end
    end

    // Interrupt status: bit0 completion, bit1 abort; write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 2'h0;
        end else begin
            irq_status_reg[0] <= complete || (irq_status_reg[0] && !(wr && req.pwdata[0]
                && hit(req.paddr, adc_ctrl_pkg::idx_irq_status)));
            irq_status_reg[1] <= (csr_wr && state_reg != adc_ctrl_pkg::st_idle)
                || (irq_status_reg[1] && !(wr && req.pwdata[1]
                && hit(req.paddr, adc_ctrl_pkg::idx_irq_status)));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= 2'h0;
        end else if (wr && hit(req.paddr, adc_ctrl_pkg::idx_irq_mask)) begin
            irq_mask_reg <= req.pwdata[1:0];
        end
    end

    always_comb begin
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b0;
        if (hit(req.paddr, adc_ctrl_pkg::idx_control_status)) begin
            prdata_next[7:0] = csr_reg;
            prdata_next[adc_ctrl_pkg::done_bit] = res_reg.valid;
        end else if (hit(req.paddr, adc_ctrl_pkg::idx_result_upper)) begin
            prdata_next[7:0] = res_reg.data[9:2];
        end else if (hit(req.paddr, adc_ctrl_pkg::idx_result_lower)) begin
            prdata_next[adc_ctrl_pkg::div4_bit] = div4_reg;
            prdata_next[1:0] = res_reg.data[1:0];
        end else if (hit(req.paddr, adc_ctrl_pkg::idx_irq_status)) begin
            prdata_next[1:0] = irq_status_reg;
        end else if (hit(req.paddr, adc_ctrl_pkg::idx_irq_mask)) begin
            prdata_next[1:0] = irq_mask_reg;
        end else if (hit(req.paddr, adc_ctrl_pkg::idx_analog_result)) begin
            prdata_next[9:0] = res_reg.data;
        end else begin
            pslverr_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (req.psel && !pready) begin
            prdata <= req.pwrite ? 32'h0000_0000 : prdata_next;
            pslverr <= pslverr_next;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // Core-facing outputs; unused codes above four fall back to input zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_channel_select <= 3'h0;
            converter_power_on <= 1'b0;
            sample_hold <= 1'b0;
            irq <= 1'b0;
        end else begin
            input_channel_select <= (csr_reg[2:0] > adc_ctrl_pkg::max_channel) ? 3'h0
                : csr_reg[2:0];
            converter_power_on <= csr_reg[adc_ctrl_pkg::power_bit];
            sample_hold <= state_reg == adc_ctrl_pkg::st_convert;
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Conversion count: ticks since load start, for timing checks
    logic [4:0] span_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            span_reg <= 5'h00;
        end else if (state_reg == adc_ctrl_pkg::st_idle
            || (csr_wr && req.pwdata[adc_ctrl_pkg::power_bit])) begin
            span_reg <= 5'h00;
        end else if (tick) begin
            span_reg <= (complete) ? 5'h00 : span_reg + 5'h01;
        end
    end

    chk_done_at_fourteen: assert property (@(posedge pclk) disable iff (!presetn)
        complete |-> span_reg == {1'b0, adc_ctrl_pkg::load_periods
        + adc_ctrl_pkg::convert_periods - 4'h1}) else $error("done not after 14 periods");
    chk_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
        complete |=> done_reg) else $error("done flag not set");
    chk_upper_clears: assert property (@(posedge pclk) disable iff (!presetn)
        upper_rd && !complete |=> !done_reg) else $error("upper read did not clear");
    chk_write_restarts: assert property (@(posedge pclk) disable iff (!presetn)
        csr_wr && req.pwdata[adc_ctrl_pkg::power_bit]
        |=> state_reg == adc_ctrl_pkg::st_load && !done_reg)
        else $error("write did not restart");
    chk_power_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
        aborted && !csr_wr |=> state_reg == adc_ctrl_pkg::st_idle && !$rose(done_reg))
        else $error("abandoned conversion completed");
    sequence s_power_write;
        csr_wr && req.pwdata[adc_ctrl_pkg::power_bit];
    endsequence
    chk_power_follows: assert property (@(posedge pclk) disable iff (!presetn)
        s_power_write |=> ##1 converter_power_on) else $error("power output not set");
    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit(req.paddr, adc_ctrl_pkg::idx_result_lower) |-> prdata[7:4] == 4'h0
        && !prdata[2]) else $error("reserved lower bits nonzero");
    chk_upper_layout: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit(req.paddr, adc_ctrl_pkg::idx_result_upper)
        |-> prdata[7:0] == $past(result_reg[9:2]))
        else $error("upper result mislaid");
    chk_fast_tick: assert property (@(posedge pclk) disable iff (!presetn)
        csr_reg[adc_ctrl_pkg::fast_bit] && !div4_reg |-> tick)
        else $error("fast clock not undivided");
endmodule // adc_control_registers

/* rtl/adc_ctrl_pkg.sv */
// Package: register map, field layout and timing constants of the converter control block
package adc_ctrl_pkg;
    // Printed offsets 0x34..0x36 are not all multiples of four: they are indices
    localparam logic [7:0] idx_control_status = 8'h34;
    localparam logic [7:0] idx_result_upper = 8'h35;
    localparam logic [7:0] idx_result_lower = 8'h36;
    localparam logic [7:0] idx_irq_status = 8'h37;
    localparam logic [7:0] idx_irq_mask = 8'h38;
    localparam logic [7:0] idx_analog_result = 8'h39;
    localparam int addr_lsb = 2;

    // Control/status field positions
    localparam int done_bit = 7;
    localparam int fast_bit = 6;
    localparam int power_bit = 5;
    localparam logic [7:0] csr_write_mask = 8'h67;
    // Lower result register: bit 3 holds divide-by-four
    localparam int div4_bit = 3;

    localparam logic [7:0] reset_byte = 8'h00;
    localparam logic [2:0] max_channel = 3'h4;

    // Conversion phases, in converter-clock periods
    localparam logic [3:0] load_periods = 4'h4;
    localparam logic [3:0] convert_periods = 4'ha;
    localparam logic [1:0] div_by_two_top = 2'h1;
    localparam logic [1:0] div_by_four_top = 2'h3;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_load = 3'b010,
        st_convert = 3'b100
    } conv_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [9:0] data;
        logic valid;
    } conv_result_t;
endpackage

/* verification/test_adc_control_registers.sv */
// Self-checking testbench of the converter control block over APB
`timescale 1ns/1ps
module test_adc_control_registers;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] analog_sample = 10'h2b5;
    logic [2:0] input_channel_select;
    logic converter_power_on;
    logic sample_hold;
    logic irq;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    int cycles_dummy;

    adc_control_registers dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_sample(analog_sample),
        .input_channel_select(input_channel_select), .converter_power_on(converter_power_on),
        .sample_hold(sample_hold), .irq(irq));

    always #25 pclk = ~pclk;

    // Byte address is four times the register index
    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic close_out;
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Runaway guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            close_out;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; entered just after a rising edge, leaves one idle edge behind it
    task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ba(idx);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        xfer(idx, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    // Cycles for which sample_hold stays high in the next whole convert phase
    task automatic hold_len(output int n);
        int i;
        n = 0;
        // Skip the tail of a convert phase already under way
        while (sample_hold === 1'b1) @(posedge pclk);
        for (i = 0; i < 400 && sample_hold !== 1'b1; i++) @(posedge pclk);
        while (sample_hold === 1'b1 && n < 400) begin
            n++;
            @(posedge pclk);
        end
    endtask

    task automatic t_reset_map;
        rd_chk(adc_ctrl_pkg::idx_control_status, 32'h0);
        rd_chk(adc_ctrl_pkg::idx_result_upper, 32'h0);
        rd_chk(adc_ctrl_pkg::idx_result_lower, 32'h0);
        xfer(8'h7f, 1'b0, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask

    task automatic t_fields;
        int c;
        for (c = 0; c < 5; c++) begin
            // Bit 7 written high must be ignored; reserved bits stay zero
            xfer(adc_ctrl_pkg::idx_control_status, 1'b1, 32'h80 | c);
            rd_chk(adc_ctrl_pkg::idx_control_status, c);
            chk({29'h0, input_channel_select}, c);
        end
        // Unused channel codes fall back to input zero
        xfer(adc_ctrl_pkg::idx_control_status, 1'b1, 32'h07);
        rd_chk(adc_ctrl_pkg::idx_control_status, 32'h07);
        chk({29'h0, input_channel_select}, 32'h0);
        chk({31'h0, converter_power_on}, 32'h0);
        xfer(adc_ctrl_pkg::idx_result_lower, 1'b1, 32'hff);
        rd_chk(adc_ctrl_pkg::idx_result_lower, 32'h08);
    endtask

    task automatic t_clock_rates;
        int k;
        int n;
        int exp_n[3] = '{20, 10, 40};
        for (k = 0; k < 3; k++) begin
            xfer(adc_ctrl_pkg::idx_result_lower, 1'b1, (k == 2) ? 32'h08 : 32'h00);
            xfer(adc_ctrl_pkg::idx_control_status, 1'b1, (k == 0) ? 32'h22 : 32'h62);
            hold_len(n);
            chk({31'h0, converter_power_on}, 32'h1);
            chk(n, exp_n[k]);
        end
    endtask

    // Runs in divide-by-four mode, where a conversion spans 56 cycles
    task automatic t_done_irq;
        xfer(adc_ctrl_pkg::idx_irq_mask, 1'b1, 32'h1);
        xfer(adc_ctrl_pkg::idx_irq_status, 1'b1, 32'h3);
        hold_len(cycles_dummy);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rd_chk(adc_ctrl_pkg::idx_control_status, 32'he2);
        rd_chk(adc_ctrl_pkg::idx_result_upper, 32'had);
        rd_chk(adc_ctrl_pkg::idx_control_status, 32'h62);
        rd_chk(adc_ctrl_pkg::idx_result_lower, 32'h09);
        rd_chk(adc_ctrl_pkg::idx_analog_result, 32'h2b5);
        xfer(adc_ctrl_pkg::idx_irq_status, 1'b1, 32'h1);
        // The registered interrupt output follows the cleared status one edge later
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        xfer(adc_ctrl_pkg::idx_irq_mask, 1'b1, 32'h0);
    endtask

    task automatic t_restart_and_stop;
        hold_len(cycles_dummy);
        repeat (3) @(posedge pclk);
        xfer(adc_ctrl_pkg::idx_control_status, 1'b1, 32'h62);
        rd_chk(adc_ctrl_pkg::idx_control_status, 32'h62);
        xfer(adc_ctrl_pkg::idx_irq_status, 1'b0, 32'h0);
        chk(rd & 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h0);
        while (sample_hold !== 1'b1) @(posedge pclk);
        xfer(adc_ctrl_pkg::idx_control_status, 1'b1, 32'h02);
        repeat (100) @(posedge pclk);
        chk({30'h0, converter_power_on, sample_hold}, 32'h0);
        rd_chk(adc_ctrl_pkg::idx_control_status, 32'h02);
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_map;
        t_fields;
        t_clock_rates;
        t_done_irq;
        t_restart_and_stop;
        close_out;
    end
endmodule // test_adc_control_registers
